//--- rtl/mcsr_pkg.sv
`default_nettype none
package mcsr_pkg;
	// Register indices; the AXI byte address is four times the index
	localparam logic [7:0] IDX_STACK = 8'h81;
	localparam logic [7:0] IDX_DP0_LO = 8'h82;
	localparam logic [7:0] IDX_DP0_HI = 8'h83;
	localparam logic [7:0] IDX_DP1_LO = 8'h84;
	localparam logic [7:0] IDX_DP1_HI = 8'h85;
	localparam logic [7:0] IDX_TIMING = 8'h8E;
	localparam logic [7:0] IDX_SELECT = 8'h92;
	localparam logic [7:0] IDX_FLAGS = 8'hD0;
	localparam logic [7:0] IDX_AUX = 8'hF0;
	localparam logic [7:0] RST_STACK = 8'h07;
	localparam logic [7:0] RST_DP0 = 8'h00;
	localparam logic [7:0] RST_TIMING = 8'h01;
	localparam logic RST_SELECT = 1'b0;
	localparam logic [6:0] RST_FLAGS = 7'h00;
	localparam logic [7:0] RST_AUX = 8'h00;
	localparam int FLAG_CARRY = 7;
	localparam int FLAG_HALF = 6;
	localparam int FLAG_WRAP = 2;
	localparam int FLAG_BANK_HI = 4;
	localparam int FLAG_BANK_LO = 3;
	localparam logic [7:0] TIMING_MASK = 8'h77;
	localparam int WAIT_HI = 6;
	localparam int WAIT_LO = 4;
	localparam int STRETCH_HI = 2;
	localparam int STRETCH_LO = 0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int SCRATCH_DEPTH = 256;
	localparam int SCRATCH_AW = 8;
	localparam logic [7:0] DIRECT_LIMIT = 8'h80;
	localparam int XRAM_DEPTH = 2048;
	localparam int XRAM_AW = 11;
	localparam logic [15:0] XRAM_BASE = 16'h8000;
	localparam logic [15:0] XRAM_LAST = 16'h87FF;
	localparam logic [7:0] ONE8 = 8'h01;

	typedef enum logic [1:0] {
		X_IDLE = 2'b00,
		X_STRETCH = 2'b01
	} mcsr_xstate_e;

	// Word aligned and inside the 256-entry index window
	function automatic logic addrAligned(input logic [11:0] byteAddr);
		return (byteAddr[1:0] == 2'h0) && (byteAddr[11:10] == 2'h0);
	endfunction: addrAligned

	function automatic logic [15:0] ptrSum(input logic [15:0] base, input logic [7:0] acc,
		input logic addAcc);
		return 16'(base + (addAcc ? {8'h00, acc} : 16'h0000));
	endfunction: ptrSum
endpackage: mcsr_pkg
`default_nettype wire

//--- rtl/mcsr_ram.sv
`default_nettype none
module mcsr_ram #(
	parameter int DEPTH = 256,
	parameter int AW = 8
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] wAddr,
	input wire logic [7:0] wData,
	input wire logic [AW-1:0] rAddr,
	output logic [7:0] rData
);
	// Contents are undefined after power-up, as for real SRAM
	logic [7:0] mem [DEPTH];

	assign rData = mem[rAddr];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[wAddr] <= wData;
		end
	end
endmodule: mcsr_ram
`default_nettype wire

//--- rtl/mcsr_stretch.sv
`default_nettype none
module mcsr_stretch
	import mcsr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [2:0] count,
	output logic done
);
	logic busy_q;
	logic [2:0] remain_q;

	assign done = busy_q && (remain_q == 3'h0);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
			remain_q <= 3'h0;
		end else if (start) begin
			busy_q <= 1'b1;
			remain_q <= count;
		end else if (done) begin
			busy_q <= 1'b0;
		end else if (busy_q) begin
			remain_q <= 3'(remain_q - 3'h1); // One core cycle per stretch count
		end
	end
endmodule: mcsr_stretch
`default_nettype wire

//--- rtl/mcsr_top.sv
// Summary of operation
// - Aux register is a mul/div operand and result byte, else scratch; resets zero.
// - Flags bit 7 is carry and Boolean accumulator; flags reset to zero.
// - Flags bit 6 reflects carry from accumulator bit 3 into bit 4.
// - Flags bits 4:3 pick one of four eight-byte register banks.
// - Flags bit 2 is signed overflow; bits 5 and 1 are plain user flags.
// - Flags bit 0 is accumulator odd parity, hardware only, ignores writes.
// - Stack pointer increments before push, decrements after pop; resets 0x07.
// - Data pointer accessed as two bytes or one 16-bit value.
// - Second data pointer behaves alike at its own addresses, not reset.
// - Select bit 0 picks active data pointer; bits 7:1 unused; resets zero.
// - Active pointer addresses external data, table reads, computed jump, plus accumulator.
// - Internal RAM 256 bytes; upper half reachable only indirectly.
// - 2048-byte external RAM decoded at 0x8000 to 0x87FF.
// - Timing bits 6:4 give zero to seven program-memory wait states.
// - Timing bits 2:0 give stretch, default one; register resets 0x01.
`default_nettype none
module mcsr_top
	import mcsr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] accValue,
	input wire logic carryWe,
	input wire logic carryIn,
	input wire logic auxCarryWe,
	input wire logic auxCarryIn,
	input wire logic wrapWe,
	input wire logic wrapIn,
	input wire logic auxWe,
	input wire logic [7:0] auxIn,
	input wire logic stackPush,
	input wire logic stackPop,
	input wire logic [7:0] pushData,
	input wire logic dptrWe,
	input wire logic [15:0] dptrIn,
	input wire logic ramReq,
	input wire logic ramWe,
	input wire logic ramIndirect,
	input wire logic [7:0] ramAddr,
	input wire logic [7:0] ramWrData,
	input wire logic xReq,
	input wire logic xWe,
	input wire logic xUsePtr,
	input wire logic xAddAcc,
	input wire logic [15:0] xAddr,
	input wire logic [7:0] xWrData,
	output logic [7:0] flags_q,
	output logic [7:0] aux_q,
	output logic [7:0] stack_q,
	output logic [15:0] activePtr_q,
	output logic [15:0] ptrPlusAcc_q,
	output logic [7:0] bankBase_q,
	output logic [7:0] timing_q,
	output logic [7:0] ramRdData_q,
	output logic ramValid_q,
	output logic ramErr_q,
	output logic xBusy_q,
	output logic [7:0] xRdData_q,
	output logic xDone_q,
	output logic xErr_q
);
	logic awHeld_q, wHeld_q;
	logic [11:0] awAddr_q;
	logic [7:0] wByte_q;
	logic wLane_q;
	logic [6:0] flagBits_q;
	logic [15:0] dp0_q, dp1_q;
	logic sel_q;
	mcsr_xstate_e xState_q;
	logic [15:0] xAddrHeld_q;
	logic xWeHeld_q;
	logic [7:0] xDataHeld_q;

	// Write path decode
	wire commit = awHeld_q && wHeld_q && !s_axi_bvalid;
	wire [7:0] wIdx = awAddr_q[9:2];
	wire wMapped = addrAligned(awAddr_q) && (wIdx == IDX_STACK || wIdx == IDX_DP0_LO ||
		wIdx == IDX_DP0_HI || wIdx == IDX_DP1_LO || wIdx == IDX_DP1_HI ||
		wIdx == IDX_TIMING || wIdx == IDX_SELECT || wIdx == IDX_FLAGS || wIdx == IDX_AUX);
	wire busWr = commit && wMapped && wLane_q;
	wire wrStack = busWr && (wIdx == IDX_STACK);
	wire wrDp0Lo = busWr && (wIdx == IDX_DP0_LO);
	wire wrDp0Hi = busWr && (wIdx == IDX_DP0_HI);
	wire wrDp1Lo = busWr && (wIdx == IDX_DP1_LO);
	wire wrDp1Hi = busWr && (wIdx == IDX_DP1_HI);
	wire wrTiming = busWr && (wIdx == IDX_TIMING);
	wire wrSelect = busWr && (wIdx == IDX_SELECT);
	wire wrFlags = busWr && (wIdx == IDX_FLAGS);
	wire wrAux = busWr && (wIdx == IDX_AUX);

	// Read path decode
	wire [7:0] rIdx = s_axi_araddr[9:2];
	wire parity = ^accValue;
	wire [7:0] flagsLive = {flagBits_q, parity};
	wire rOk = addrAligned(s_axi_araddr);
	wire [7:0] rByte =
		(rIdx == IDX_STACK) ? stack_q :
		(rIdx == IDX_DP0_LO) ? dp0_q[7:0] :
		(rIdx == IDX_DP0_HI) ? dp0_q[15:8] :
		(rIdx == IDX_DP1_LO) ? dp1_q[7:0] :
		(rIdx == IDX_DP1_HI) ? dp1_q[15:8] :
		(rIdx == IDX_TIMING) ? timing_q :
		(rIdx == IDX_SELECT) ? {7'h00, sel_q} :
		(rIdx == IDX_FLAGS) ? flagsLive :
		(rIdx == IDX_AUX) ? aux_q : 8'h00;
	wire rMapped = rOk && (rIdx == IDX_STACK || rIdx == IDX_DP0_LO || rIdx == IDX_DP0_HI ||
		rIdx == IDX_DP1_LO || rIdx == IDX_DP1_HI || rIdx == IDX_TIMING ||
		rIdx == IDX_SELECT || rIdx == IDX_FLAGS || rIdx == IDX_AUX);
	wire arTake = s_axi_arvalid && s_axi_arready;

	// Next values; core updates win over a bus write in the same cycle
	wire [6:0] flagsBus = wrFlags ? wByte_q[7:1] : flagBits_q;
	wire [6:0] flags_d = {carryWe ? carryIn : flagsBus[6],
		auxCarryWe ? auxCarryIn : flagsBus[5],
		flagsBus[4:2],
		wrapWe ? wrapIn : flagsBus[1],
		flagsBus[0]};
	wire [7:0] stack_d = stackPush ? 8'(stack_q + ONE8) :
		stackPop ? 8'(stack_q - ONE8) :
		wrStack ? wByte_q : stack_q;
	wire [15:0] dp0_d = (dptrWe && !sel_q) ? dptrIn :
		{wrDp0Hi ? wByte_q : dp0_q[15:8], wrDp0Lo ? wByte_q : dp0_q[7:0]};
	wire [15:0] dp1_d = (dptrWe && sel_q) ? dptrIn :
		{wrDp1Hi ? wByte_q : dp1_q[15:8], wrDp1Lo ? wByte_q : dp1_q[7:0]};
	wire sel_d = wrSelect ? wByte_q[0] : sel_q;
	wire [15:0] activePtr_d = sel_d ? dp1_d : dp0_d;
	wire [7:0] aux_d = auxWe ? auxIn : (wrAux ? wByte_q : aux_q);
	// Wait-state field is kept for the fetch unit, which reads it from timing_q
	wire [7:0] timing_d = wrTiming ? (wByte_q & TIMING_MASK) : timing_q;

	// Internal scratch memory: stack traffic first, then plain accesses
	wire directHigh = ramReq && !ramIndirect && (ramAddr >= DIRECT_LIMIT);
	wire ramWrite = stackPush || (ramReq && ramWe && !directHigh && !stackPop);
	wire [7:0] ramWAddr = stackPush ? 8'(stack_q + ONE8) : ramAddr;
	wire [7:0] ramWData = stackPush ? pushData : ramWrData;
	wire [7:0] ramRAddr = stackPop ? stack_q : ramAddr;
	wire ramRead = stackPop || (ramReq && !ramWe && !directHigh && !stackPush);
	wire [7:0] ramRData;

	mcsr_ram #(
		.DEPTH(SCRATCH_DEPTH),
		.AW(SCRATCH_AW)
	) u_internal_scratch_memory (
		.clk(clk),
		.we(ramWrite),
		.wAddr(ramWAddr),
		.wData(ramWData),
		.rAddr(ramRAddr),
		.rData(ramRData)
	);

	// External data RAM with stretched access
	wire [15:0] xEff = xUsePtr ? ptrSum(activePtr_q, accValue, xAddAcc) : xAddr;
	wire xTake = xReq && (xState_q == X_IDLE);
	wire xHit = (xAddrHeld_q >= XRAM_BASE) && (xAddrHeld_q <= XRAM_LAST);
	wire stretchDone;
	wire [7:0] xRData;
	wire [XRAM_AW-1:0] xIdx = xAddrHeld_q[XRAM_AW-1:0];
	wire xFinish = (xState_q == X_STRETCH) && stretchDone;

	mcsr_stretch u_stretch (
		.clk(clk),
		.rst_n(rst_n),
		.start(xTake),
		.count(timing_q[STRETCH_HI:STRETCH_LO]),
		.done(stretchDone)
	);

	mcsr_ram #(
		.DEPTH(XRAM_DEPTH),
		.AW(XRAM_AW)
	) u_external_ram (
		.clk(clk),
		.we(xFinish && xHit && xWeHeld_q),
		.wAddr(xIdx),
		.wData(xDataHeld_q),
		.rAddr(xIdx),
		.rData(xRData)
	);

	// AXI write channel
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= 12'h000;
			wByte_q <= 8'h00;
			wLane_q <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awAddr_q <= s_axi_awaddr;
				awHeld_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end else if (!awHeld_q && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wByte_q <= s_axi_wdata[7:0];
				wLane_q <= s_axi_wstrb[0];
				wHeld_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end else if (!wHeld_q && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (commit) begin
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wMapped ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI read channel
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (arTake) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rMapped ? rByte : 8'h00};
			s_axi_rresp <= rMapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	// Special registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flagBits_q <= RST_FLAGS;
			stack_q <= RST_STACK;
			dp0_q <= {RST_DP0, RST_DP0};
			sel_q <= RST_SELECT;
			aux_q <= RST_AUX;
			timing_q <= RST_TIMING;
		end else begin
			flagBits_q <= flags_d;
			stack_q <= stack_d;
			dp0_q <= dp0_d;
			sel_q <= sel_d;
			aux_q <= aux_d;
			timing_q <= timing_d;
		end
	end

	// Second pointer keeps its value across reset
	always_ff @(posedge clk) begin
		dp1_q <= dp1_d;
	end

	// Registered views for the execution unit
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flags_q <= 8'h00;
			activePtr_q <= {RST_DP0, RST_DP0};
			ptrPlusAcc_q <= 16'h0000;
			bankBase_q <= 8'h00;
		end else begin
			flags_q <= {flags_d, parity};
			activePtr_q <= activePtr_d;
			ptrPlusAcc_q <= ptrSum(activePtr_d, accValue, 1'b1);
			bankBase_q <= {3'h0, flags_d[FLAG_BANK_HI-1:FLAG_BANK_LO-1], 3'h0};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ramRdData_q <= 8'h00;
			ramValid_q <= 1'b0;
			ramErr_q <= 1'b0;
		end else begin
			ramRdData_q <= ramRead ? ramRData : 8'h00;
			ramValid_q <= ramRead;
			ramErr_q <= directHigh && !stackPush && !stackPop;
		end
	end

	// External access sequencer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			xState_q <= X_IDLE;
			xAddrHeld_q <= 16'h0000;
			xWeHeld_q <= 1'b0;
			xDataHeld_q <= 8'h00;
			xBusy_q <= 1'b0;
			xRdData_q <= 8'h00;
			xDone_q <= 1'b0;
			xErr_q <= 1'b0;
		end else begin
			xDone_q <= 1'b0;
			xErr_q <= 1'b0;
			case (xState_q)
				X_IDLE: begin
					if (xReq) begin
						xAddrHeld_q <= xEff;
						xWeHeld_q <= xWe;
						xDataHeld_q <= xWrData;
						xBusy_q <= 1'b1;
						xState_q <= X_STRETCH;
					end
				end
				X_STRETCH: begin
					if (stretchDone) begin
						xRdData_q <= (xHit && !xWeHeld_q) ? xRData : 8'h00;
						xDone_q <= 1'b1;
						xErr_q <= !xHit;
						xBusy_q <= 1'b0;
						xState_q <= X_IDLE;
					end
				end
				default: begin
					xState_q <= X_IDLE;
				end
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_aux_load:
		assert property (auxWe |=> aux_q == $past(auxIn)) else $error("aux load lost");
	a_carry_update:
		assert property (carryWe |=> flags_q[FLAG_CARRY] == $past(carryIn))
			else $error("carry lost");
	a_halfcarry_update:
		assert property (auxCarryWe |=> flags_q[FLAG_HALF] == $past(auxCarryIn))
			else $error("aux carry lost");
	a_wrap_update:
		assert property (wrapWe |=> flags_q[FLAG_WRAP] == $past(wrapIn)) else $error("wrap lost");
	a_parity_track:
		assert property (##1 flags_q[0] == ^$past(accValue)) else $error("parity wrong");
	a_stack_push:
		assert property (stackPush |=> stack_q == 8'($past(stack_q) + ONE8))
			else $error("push did not increment");
	a_stack_pop:
		assert property (stackPop && !stackPush |=> stack_q == 8'($past(stack_q) - ONE8))
			else $error("pop did not decrement");
	a_bank_base:
		assert property (##1 bankBase_q[2:0] == 3'h0 && bankBase_q[7:5] == 3'h0 &&
			bankBase_q[4:3] == flagBits_q[FLAG_BANK_HI-1:FLAG_BANK_LO-1])
			else $error("bank base mismatch");
	a_unused_zero:
		assert property (timing_q[7] == 1'b0 && timing_q[3] == 1'b0) else $error("unused bit set");
	a_direct_refuse:
		assert property (directHigh && !stackPush && !stackPop |=> ramErr_q && !ramValid_q)
			else $error("direct high access not refused");
	a_stretch_zero:
		assert property (xTake && timing_q[2:0] == 3'h0 |=> !xDone_q ##1 xDone_q)
			else $error("zero stretch timing wrong");
	a_stretch_one:
		assert property (xTake && timing_q[2:0] == 3'h1 |=> !xDone_q [*2] ##1 xDone_q)
			else $error("one stretch timing wrong");

	c_push_pop: cover property (stackPush ##1 stackPop);
	c_bus_write: cover property (busWr && wIdx == IDX_SELECT);
	c_xram_read: cover property (xFinish && xHit && !xWeHeld_q);
	c_bus_read: cover property (arTake && rIdx == IDX_FLAGS);
endmodule: mcsr_top
`default_nettype wire

//--- verification/mcsr_exec_model.sv
`default_nettype none
module mcsr_exec_model
	import mcsr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic [26:0] cmd,
	input wire logic xBusy_q,
	input wire logic xDone_q,
	input wire logic xErr_q,
	input wire logic [7:0] xRdData_q,
	output logic xReq,
	output logic xWe,
	output logic xUsePtr,
	output logic xAddAcc,
	output logic [15:0] xAddr,
	output logic [7:0] xWrData,
	output logic fin,
	output logic [3:0] finLat,
	output logic [7:0] finData,
	output logic finErr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy;
	logic [3:0] cnt;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{xReq, xWe, xUsePtr, xAddAcc, busy, fin, finErr} <= '0;
			{xAddr, xWrData, cnt, finLat, finData} <= '0;
		end else begin
			fin <= 1'b0;
			if (go && !busy) begin
				{xWe, xUsePtr, xAddAcc, xAddr, xWrData} <= cmd;
				xReq <= 1'b1;
				busy <= 1'b1;
			end else begin
				xReq <= 1'b0;
				// Released lines toggle so a stale latch cannot pass unseen
				xAddr <= ~xAddr;
				xWrData <= ~xWrData;
			end
			if (xReq && !xBusy_q) cnt <= 4'h1;
			else if (busy && cnt != 4'h0) cnt <= cnt + 4'h1;
			if (busy && (xDone_q || xErr_q)) begin
				busy <= 1'b0;
				cnt <= 4'h0;
				fin <= 1'b1;
				finLat <= cnt;
				finData <= xRdData_q;
				finErr <= xErr_q;
			end
		end
	end
endmodule: mcsr_exec_model
`default_nettype wire

//--- verification/test_mcsr_top.sv
`default_nettype none
module test_mcsr_top
	import mcsr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = '0;
	logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic s_axi_arvalid = '0, s_axi_rready = '0;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	logic [7:0] accValue = '0, auxIn = '0, pushData = '0, ramAddr = '0, ramWrData = '0;
	logic carryWe = '0, carryIn = '0, auxCarryWe = '0, auxCarryIn = '0, wrapWe = '0;
	logic wrapIn = '0, auxWe = '0, stackPush = '0, stackPop = '0, dptrWe = '0;
	logic ramReq = '0, ramWe = '0, ramIndirect = '0, go = '0;
	logic [15:0] dptrIn = '0, p;
	logic [26:0] cmd = '0;
	wire logic xReq, xWe, xUsePtr, xAddAcc, fin, finErr;
	wire logic [15:0] xAddr, activePtr_q, ptrPlusAcc_q;
	wire logic [7:0] xWrData, finData, flags_q, aux_q, stack_q, bankBase_q, timing_q;
	wire logic [7:0] ramRdData_q, xRdData_q;
	wire logic [3:0] finLat;
	wire logic ramValid_q, ramErr_q, xBusy_q, xDone_q, xErr_q;
	logic [33:0] rq[$];
	logic [13:0] xq[$];
	logic [13:0] xn;
	logic [7:0] r, v, rd;
	logic er;
	int n_mismatch = 0, n_tests = 0, cyc = 0;

	mcsr_top dut_u (.*);
	mcsr_exec_model core_u (.*);

	always #10 clk = ~clk;

	task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
		n_tests++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask: chk

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask: tally_and_finish

	task automatic axi_wr(input logic [7:0] idx, d, input logic [3:0] st, input logic [1:0] e);
		int n;
		@(posedge clk);
		s_axi_awaddr <= {2'h0, idx, 2'h0};
		s_axi_wdata <= {24'h000000, d};
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 40);
		s_axi_bready <= 1'b0;
		chk("bresp", {32'h0, e}, {32'h0, s_axi_bresp});
	endtask: axi_wr

	task automatic axi_rd(input logic [7:0] idx, d, input logic [1:0] e);
		int n;
		rq.push_back({e, 24'h000000, d});
		@(posedge clk);
		s_axi_araddr <= {2'h0, idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 40);
		s_axi_rready <= 1'b0;
	endtask: axi_rd

	task automatic ram_op(input logic w, ind, input logic [7:0] a, d);
		int n;
		@(posedge clk);
		ramReq <= 1'b1;
		{ramWe, ramIndirect, ramAddr, ramWrData} <= {w, ind, a, d};
		@(posedge clk);
		ramReq <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ramValid_q !== 1'b1 && ramErr_q !== 1'b1 && n < 4);
		rd = ramRdData_q;
		er = ramErr_q;
	endtask: ram_op

	// Note holds data-compare flag, error, data and edge count take-to-done
	task automatic ext_op(input logic [26:0] c, input logic [13:0] note);
		int n;
		xq.push_back(note);
		@(posedge clk);
		go <= 1'b1;
		cmd <= c;
		@(posedge clk);
		go <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (fin !== 1'b1 && n < 20);
	endtask: ext_op

	task automatic strobe_core(input logic [7:0] a, input logic e);
		@(posedge clk);
		{carryWe, auxCarryWe, wrapWe, auxWe} <= 4'hF;
		{carryIn, auxCarryIn, wrapIn, auxIn} <= {e, !e, e, a};
		@(posedge clk);
		{carryWe, auxCarryWe, wrapWe, auxWe} <= 4'h0;
		@(posedge clk);
	endtask: strobe_core

	always @(posedge clk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && rq.size() > 0)
			chk("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (fin === 1'b1 && xq.size() > 0) begin
			xn = xq.pop_front();
			chk("xbusy", 34'h0, {33'h0, xBusy_q});
			chk("xerr", {33'h0, xn[12]}, {33'h0, finErr});
			if (xn[13]) chk("xdata", {26'h0, xn[11:4]}, {26'h0, finData});
			if (!xn[12]) chk("xlat", {30'h0, xn[3:0]}, {30'h0, finLat});
		end
	end

	// Whole run needs a few hundred cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	initial begin
		void'($urandom(32'hC9515BDE));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		axi_rd(IDX_STACK, 8'h07, RESP_OKAY);
		axi_rd(IDX_DP0_LO, 8'h00, RESP_OKAY);
		axi_rd(IDX_DP0_HI, 8'h00, RESP_OKAY);
		axi_rd(IDX_TIMING, 8'h01, RESP_OKAY);
		axi_rd(IDX_SELECT, 8'h00, RESP_OKAY);
		axi_rd(IDX_FLAGS, 8'h00, RESP_OKAY);
		axi_rd(IDX_AUX, 8'h00, RESP_OKAY);
		axi_rd(8'h90, 8'h00, RESP_SLVERR);
		axi_wr(8'h90, 8'h55, 4'h1, RESP_SLVERR);
		r = 8'($urandom);
		axi_wr(IDX_AUX, r, 4'h1, RESP_OKAY);
		axi_wr(IDX_AUX, ~r, 4'h0, RESP_OKAY);
		axi_rd(IDX_AUX, r, RESP_OKAY);
		axi_wr(IDX_SELECT, 8'hFF, 4'h1, RESP_OKAY);
		axi_rd(IDX_SELECT, 8'h01, RESP_OKAY);
		axi_wr(IDX_TIMING, 8'hFF, 4'h1, RESP_OKAY);
		axi_rd(IDX_TIMING, 8'h77, RESP_OKAY);
		axi_wr(IDX_TIMING, 8'h01, 4'h1, RESP_OKAY);
		for (int k = 0; k < 4; k++) begin
			v = {3'($urandom), 2'(k), 3'($urandom)};
			accValue <= 8'($urandom);
			axi_wr(IDX_FLAGS, v, 4'h1, RESP_OKAY);
			axi_rd(IDX_FLAGS, {v[7:1], ^accValue}, RESP_OKAY);
			chk("flagsbank", {18'h0, v[7:1], ^accValue, 8'(k * 8)}, {18'h0, flags_q, bankBase_q});
		end
		for (int e = 0; e < 2; e++) begin
			r = 8'($urandom);
			strobe_core(r, e[0]);
			chk("coreflags", {23'h0, e[0], !e[0], e[0], r},
				{23'h0, flags_q[7], flags_q[6], flags_q[2], aux_q});
		end
		axi_wr(IDX_STACK, 8'hA0, 4'h1, RESP_OKAY);
		@(posedge clk);
		stackPush <= 1'b1;
		pushData <= 8'h3C;
		@(posedge clk);
		pushData <= 8'hC3;
		@(posedge clk);
		stackPush <= 1'b0;
		@(posedge clk);
		chk("stack", {26'h0, 8'hA2}, {26'h0, stack_q});
		ram_op(1'b0, 1'b1, 8'hA2, 8'h00);
		chk("pushtop", {25'h0, 9'h0C3}, {25'h0, er, rd});
		ram_op(1'b0, 1'b1, 8'hA1, 8'h00);
		chk("pushlow", {25'h0, 9'h03C}, {25'h0, er, rd});
		@(posedge clk);
		stackPop <= 1'b1;
		@(posedge clk);
		stackPop <= 1'b0;
		@(posedge clk);
		chk("pop", {26'h0, 8'hA1}, {26'h0, stack_q});
		r = 8'($urandom);
		ram_op(1'b1, 1'b0, 8'h7F, r);
		ram_op(1'b0, 1'b1, 8'h7F, 8'h00);
		chk("direct", {25'h0, 1'b0, r}, {25'h0, er, rd});
		ram_op(1'b1, 1'b1, 8'hFF, ~r);
		ram_op(1'b0, 1'b1, 8'hFF, 8'h00);
		chk("upper", {25'h0, 1'b0, ~r}, {25'h0, er, rd});
		ram_op(1'b0, 1'b0, 8'h80, 8'h00);
		chk("directhigh", {33'h0, 1'b1}, {33'h0, er});
		axi_wr(IDX_DP0_LO, 8'h10, 4'h1, RESP_OKAY);
		axi_wr(IDX_DP0_HI, 8'h80, 4'h1, RESP_OKAY);
		@(posedge clk);
		dptrWe <= 1'b1;
		dptrIn <= 16'h8123;
		@(posedge clk);
		dptrWe <= 1'b0;
		axi_rd(IDX_DP1_LO, 8'h23, RESP_OKAY);
		axi_rd(IDX_DP1_HI, 8'h81, RESP_OKAY);
		chk("ptr1", {2'h0, 16'h8123, 16'(16'h8123 + accValue)},
			{2'h0, activePtr_q, ptrPlusAcc_q});
		axi_wr(IDX_SELECT, 8'h00, 4'h1, RESP_OKAY);
		repeat (2) @(posedge clk);
		chk("ptr0", {18'h0, 16'h8010}, {18'h0, activePtr_q});
		r = 8'($urandom);
		ext_op({3'b110, 16'h0000, r}, 14'h0003);
		ext_op({3'b000, 16'h8010, 8'h00}, {2'b10, r, 4'h3});
		axi_wr(IDX_TIMING, 8'h00, 4'h1, RESP_OKAY);
		ext_op({3'b100, 16'h87FF, ~r}, 14'h0002);
		p = 16'h87FF - {8'h00, accValue};
		axi_wr(IDX_DP0_LO, p[7:0], 4'h1, RESP_OKAY);
		axi_wr(IDX_DP0_HI, p[15:8], 4'h1, RESP_OKAY);
		ext_op({3'b011, 16'h0000, 8'h00}, {2'b10, ~r, 4'h2});
		ext_op({3'b000, 16'h8800, 8'h00}, 14'h1000);
		ext_op({3'b000, 16'h7FFF, 8'h00}, 14'h1000);
		// Mid-run reset: second pointer must survive, select (already zero before reset) must read zero
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		axi_rd(IDX_DP1_LO, 8'h23, RESP_OKAY);
		axi_rd(IDX_SELECT, 8'h00, RESP_OKAY);
		repeat (4) @(posedge clk);
		// A lost answer leaves its note queued and must not pass
		chk("pending", 34'h0, 34'(rq.size() + xq.size()));
		tally_and_finish();
	end
endmodule: test_mcsr_top
`default_nettype wire
